// >>> core/cfs_pkg.sv
// shared constants and types of the control-flow bus sequencer
package cfs_pkg;

    localparam int          ADDR_W      = 16;
    localparam int          DATA_W      = 8;

    // -------------------------------------------------------------------
    // opcodes handled by the sequencer
    // -------------------------------------------------------------------
    localparam logic [7:0]  OP_BREAK    = 8'h00;
    localparam logic [7:0]  OP_CALL     = 8'h20;
    localparam logic [7:0]  OP_RET_INT  = 8'h40;
    localparam logic [7:0]  OP_RET_SUB  = 8'h60;
    localparam logic [7:0]  OP_JUMP_ABS = 8'h4c;
    localparam logic [7:0]  OP_JUMP_IND = 8'h6c;
    localparam logic [7:0]  BR_MASK     = 8'h1f;
    localparam logic [7:0]  BR_CODE     = 8'h10;

    // -------------------------------------------------------------------
    // memory map and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0]  STACK_PAGE  = 8'h01;
    localparam logic [15:0] VEC_NMI     = 16'hfffa;
    localparam logic [15:0] VEC_RST     = 16'hfffc;
    localparam logic [15:0] VEC_IRQ     = 16'hfffe;
    localparam logic [15:0] RESET_PC    = 16'h0000;
    localparam logic [7:0]  RESET_SP    = 8'hff;
    localparam logic [7:0]  RESET_P     = 8'h24;

    // -------------------------------------------------------------------
    // status bit positions
    // -------------------------------------------------------------------
    localparam int          P_C         = 0;
    localparam int          P_Z         = 1;
    localparam int          P_I         = 2;
    localparam int          P_B         = 4;
    localparam int          P_U         = 5;
    localparam int          P_V         = 6;
    localparam int          P_N         = 7;

    // -------------------------------------------------------------------
    // bus cycle numbers within an instruction
    // -------------------------------------------------------------------
    localparam logic [2:0]  T0 = 3'h0;
    localparam logic [2:0]  T1 = 3'h1;
    localparam logic [2:0]  T2 = 3'h2;
    localparam logic [2:0]  T3 = 3'h3;
    localparam logic [2:0]  T4 = 3'h4;
    localparam logic [2:0]  T5 = 3'h5;
    localparam logic [2:0]  T6 = 3'h6;

    typedef enum logic [2:0] {
        K_OTHER  = 3'b000,
        K_CALL   = 3'b001,
        K_BREAK  = 3'b010,
        K_RETI   = 3'b011,
        K_RETS   = 3'b100,
        K_JABS   = 3'b101,
        K_JIND   = 3'b110,
        K_BRANCH = 3'b111
    } cfs_kind_t;

    typedef enum logic [1:0] {
        SRC_SW  = 2'b00,
        SRC_IRQ = 2'b01,
        SRC_NMI = 2'b10,
        SRC_RST = 2'b11
    } cfs_src_t;

endpackage

// >>> core/cfs_sequencer.sv
// bus sequencer for call, return, break, interrupt, jump and branch cycles
`timescale 1ns/10ps
`default_nettype none
module cfs_sequencer (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_reset_n,
    input  wire logic [cfs_pkg::DATA_W-1:0] i_rdata,
    input  wire logic                       i_irq_req,
    input  wire logic                       i_nmi_req,
    output logic      [cfs_pkg::ADDR_W-1:0] o_addr,
    output logic      [cfs_pkg::DATA_W-1:0] o_wdata,
    output logic                            o_rw,
    output logic                            o_sync,
    output logic      [cfs_pkg::DATA_W-1:0] o_status
);
    import cfs_pkg::*;

    // -------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    cfs_kind_t   kind,  next_kind;
    cfs_src_t    src,   next_src;
    logic [2:0]  cyc,   next_cyc;
    logic [7:0]  op,    next_op;
    logic [15:0] pc,    next_pc;
    logic [7:0]  tlo,   next_tlo;
    logic [7:0]  thi,   next_thi;
    logic [7:0]  blo,   next_blo;
    logic [7:0]  p,     next_p;
    logic [15:0] addr,  next_addr;
    logic [7:0]  wdata, next_wdata;
    logic        rw,    next_rw;
    logic        sync,  next_sync;
    logic        nmi_prev;
    logic        nmi_pend, next_nmi_pend;
    logic        rst_pend, next_rst_pend;

    logic [15:0] pc1;
    logic [15:0] ret;
    logic [15:0] sp_addr;
    logic [15:0] sp_up_addr;
    logic [15:0] sp_dn_addr;
    logic [15:0] vec_lo;
    logic [15:0] br_tgt;
    logic        nmi_edge;
    logic        flag;
    logic        taken;

    cfs_stack_if stk ();

    cfs_stack_ptr u_stack (
        .i_clk   (i_ref_clk),
        .i_rst_n (rst_n),
        .stk     (stk.unit)
    );

    assign pc1        = pc + 16'h0001;
    assign ret        = (src == SRC_SW) ? pc1 : pc;
    assign sp_addr    = {STACK_PAGE, stk.sp};
    assign sp_up_addr = {STACK_PAGE, stk.sp_up};
    assign sp_dn_addr = {STACK_PAGE, stk.sp_dn};
    assign nmi_edge   = i_nmi_req & ~nmi_prev;
    // offset is sign extended so backward branches reach lower pages
    assign br_tgt     = pc1 + {{8{i_rdata[7]}}, i_rdata};

    always_comb begin
        unique case (src)
            SRC_NMI: vec_lo = VEC_NMI;
            SRC_RST: vec_lo = VEC_RST;
            default: vec_lo = VEC_IRQ;
        endcase
    end

    always_comb begin
        unique case (op[7:6])
            2'b00:   flag = p[P_N];
            2'b01:   flag = p[P_V];
            2'b10:   flag = p[P_C];
            default: flag = p[P_Z];
        endcase
        taken = (flag == op[5]);
    end

    // -------------------------------------------------------------------
    // next bus cycle
    // -------------------------------------------------------------------
    always_comb begin
        next_kind     = kind;
        next_src      = src;
        next_cyc      = cyc + T1;
        next_op       = op;
        next_pc       = pc;
        next_tlo      = tlo;
        next_thi      = thi;
        next_blo      = blo;
        next_p        = p;
        next_addr     = addr;
        next_wdata    = wdata;
        next_rw       = 1'b1;
        next_sync     = 1'b0;
        next_rst_pend = rst_pend;
        // a new edge in the clearing cycle keeps the request pending
        next_nmi_pend = nmi_pend | nmi_edge;
        stk.push      = 1'b0;
        stk.pull      = 1'b0;
        if (cyc == T0) begin
            next_op  = i_rdata;
            next_cyc = T1;
            if (rst_pend || nmi_pend || (i_irq_req && !p[P_I])) begin
                next_kind = K_BREAK;
                next_addr = pc;
                if (rst_pend) begin
                    next_src      = SRC_RST;
                    next_rst_pend = 1'b0;
                end else if (nmi_pend) begin
                    next_src      = SRC_NMI;
                    next_nmi_pend = nmi_edge;
                end else begin
                    next_src = SRC_IRQ;
                end
            end else begin
                next_src  = SRC_SW;
                next_addr = pc1;
                next_pc   = pc1;
                if (i_rdata == OP_BREAK) begin
                    next_kind = K_BREAK;
                end else if (i_rdata == OP_CALL) begin
                    next_kind = K_CALL;
                end else if (i_rdata == OP_RET_INT) begin
                    next_kind = K_RETI;
                end else if (i_rdata == OP_RET_SUB) begin
                    next_kind = K_RETS;
                end else if (i_rdata == OP_JUMP_ABS) begin
                    next_kind = K_JABS;
                end else if (i_rdata == OP_JUMP_IND) begin
                    next_kind = K_JIND;
                end else if ((i_rdata & BR_MASK) == BR_CODE) begin
                    next_kind = K_BRANCH;
                end else begin
                    next_kind = K_OTHER;
                end
            end
        end else begin
            unique case (kind)
                K_CALL: begin
                    if (cyc == T1) begin
                        next_tlo  = i_rdata;
                        next_pc   = pc1;
                        next_addr = sp_addr;
                    end else if (cyc == T2) begin
                        next_addr  = sp_addr;
                        next_rw    = 1'b0;
                        next_wdata = pc[15:8];
                    end else if (cyc == T3) begin
                        stk.push   = 1'b1;
                        next_addr  = sp_dn_addr;
                        next_rw    = 1'b0;
                        next_wdata = pc[7:0];
                    end else if (cyc == T4) begin
                        stk.push  = 1'b1;
                        next_addr = pc;
                    end else begin
                        next_addr = {i_rdata, tlo};
                    end
                end
                K_BREAK: begin
                    // reset entry walks the same cycles but never drives data
                    if (cyc == T1) begin
                        next_pc    = ret;
                        next_addr  = sp_addr;
                        next_rw    = (src == SRC_RST);
                        next_wdata = ret[15:8];
                    end else if (cyc == T2) begin
                        stk.push   = 1'b1;
                        next_addr  = sp_dn_addr;
                        next_rw    = (src == SRC_RST);
                        next_wdata = pc[7:0];
                    end else if (cyc == T3) begin
                        stk.push   = 1'b1;
                        next_addr  = sp_dn_addr;
                        next_rw    = (src == SRC_RST);
                        next_wdata = p | (8'h01 << P_U);
                        next_wdata[P_B] = (src == SRC_SW);
                    end else if (cyc == T4) begin
                        stk.push    = 1'b1;
                        next_p[P_I] = 1'b1;
                        next_addr   = vec_lo;
                    end else if (cyc == T5) begin
                        next_tlo  = i_rdata;
                        next_addr = vec_lo | 16'h0001;
                    end else begin
                        next_addr = {i_rdata, tlo};
                    end
                end
                K_RETI: begin
                    if (cyc == T1) begin
                        next_addr = sp_addr;
                    end else if (cyc == T2) begin
                        stk.pull  = 1'b1;
                        next_addr = sp_up_addr;
                    end else if (cyc == T3) begin
                        next_p    = i_rdata;
                        stk.pull  = 1'b1;
                        next_addr = sp_up_addr;
                    end else if (cyc == T4) begin
                        next_tlo  = i_rdata;
                        stk.pull  = 1'b1;
                        next_addr = sp_up_addr;
                    end else begin
                        next_addr = {i_rdata, tlo};
                    end
                end
                K_RETS: begin
                    if (cyc == T1) begin
                        next_addr = sp_addr;
                    end else if (cyc == T2) begin
                        stk.pull  = 1'b1;
                        next_addr = sp_up_addr;
                    end else if (cyc == T3) begin
                        next_tlo  = i_rdata;
                        stk.pull  = 1'b1;
                        next_addr = sp_up_addr;
                    end else if (cyc == T4) begin
                        next_pc   = {i_rdata, tlo};
                        next_addr = {i_rdata, tlo};
                    end else begin
                        next_addr = pc1;
                    end
                end
                K_JABS: begin
                    if (cyc == T1) begin
                        next_tlo  = i_rdata;
                        next_pc   = pc1;
                        next_addr = pc1;
                    end else begin
                        next_addr = {i_rdata, tlo};
                    end
                end
                K_JIND: begin
                    if (cyc == T1) begin
                        next_tlo  = i_rdata;
                        next_pc   = pc1;
                        next_addr = pc1;
                    end else if (cyc == T2) begin
                        next_thi  = i_rdata;
                        next_addr = {i_rdata, tlo};
                    end else if (cyc == T3) begin
                        next_blo  = i_rdata;
                        // the pointer never carries into its high byte
                        next_addr = {thi, tlo + 8'h01};
                    end else begin
                        next_addr = {i_rdata, blo};
                    end
                end
                K_BRANCH: begin
                    if (cyc == T1) begin
                        next_pc = pc1;
                        if (!taken) begin
                            next_addr = pc1;
                            next_cyc  = T0;
                        end else begin
                            next_thi  = br_tgt[15:8];
                            next_tlo  = br_tgt[7:0];
                            next_addr = {pc1[15:8], br_tgt[7:0]};
                        end
                    end else if (cyc == T2) begin
                        next_addr = {thi, tlo};
                        if (thi == pc[15:8]) begin
                            next_cyc = T0;
                        end
                    end else begin
                        next_addr = {thi, tlo};
                    end
                end
                default: begin
                    // anything else is passed over as a one byte opcode
                    next_addr = pc;
                end
            endcase
            if ((kind == K_CALL && cyc == T5) || (kind == K_BREAK && cyc == T6) ||
                (kind == K_RETI && cyc == T5) || (kind == K_RETS && cyc == T5) ||
                (kind == K_JABS && cyc == T2) || (kind == K_JIND && cyc == T4) ||
                (kind == K_BRANCH && cyc == T3) || (kind == K_OTHER)) begin
                next_cyc = T0;
            end
        end
        if (next_cyc == T0) begin
            next_pc   = next_addr;
            next_sync = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind     <= K_OTHER;
            src      <= SRC_RST;
            cyc      <= T0;
            op       <= OP_BREAK;
            pc       <= RESET_PC;
            tlo      <= 8'h00;
            thi      <= 8'h00;
            blo      <= 8'h00;
            p        <= RESET_P;
            addr     <= RESET_PC;
            wdata    <= 8'h00;
            rw       <= 1'b1;
            sync     <= 1'b1;
            nmi_prev <= 1'b0;
            nmi_pend <= 1'b0;
            rst_pend <= 1'b1;
        end else begin
            kind     <= next_kind;
            src      <= next_src;
            cyc      <= next_cyc;
            op       <= next_op;
            pc       <= next_pc;
            tlo      <= next_tlo;
            thi      <= next_thi;
            blo      <= next_blo;
            p        <= next_p;
            addr     <= next_addr;
            wdata    <= next_wdata;
            rw       <= next_rw;
            sync     <= next_sync;
            nmi_prev <= i_nmi_req;
            nmi_pend <= next_nmi_pend;
            rst_pend <= next_rst_pend;
        end
    end

    assign o_addr   = addr;
    assign o_wdata  = wdata;
    assign o_rw     = rw;
    assign o_sync   = sync;
    assign o_status = p;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    a_call_length: assert property (kind == K_CALL && cyc == T1 |-> ##5 cyc == T0)
        else $error("call not six cycles");
    a_call_push_hi: assert property (kind == K_CALL && cyc == T3 |->
        !o_rw && o_addr == $past(o_addr))
        else $error("call high byte push wrong");
    a_call_push_lo: assert property (kind == K_CALL && cyc == T4 |->
        !o_rw && o_addr == $past(o_addr) - 16'h0001)
        else $error("call low byte push wrong");
    a_break_length: assert property (kind == K_BREAK && cyc == T1 |-> ##6 cyc == T0)
        else $error("break not seven cycles");
    a_break_writes: assert property (kind == K_BREAK && cyc == T2 && src != SRC_RST |->
        !o_rw [*3])
        else $error("break pushes not written");
    a_vector_low: assert property (kind == K_BREAK && cyc == T5 |-> o_addr == vec_lo)
        else $error("wrong vector low address");
    a_vector_high: assert property (kind == K_BREAK && cyc == T6 |->
        o_addr == ($past(o_addr) | 16'h0001) && p[P_I])
        else $error("wrong vector high address");
    a_reti_length: assert property (kind == K_RETI && cyc == T1 |-> ##5 cyc == T0)
        else $error("interrupt return not six cycles");
    a_rets_resume: assert property (kind == K_RETS && cyc == T5 |=>
        o_sync && o_addr == $past(o_addr) + 16'h0001)
        else $error("subroutine return resume wrong");
    a_jump_length: assert property (kind == K_JABS && cyc == T1 |-> ##2 o_sync)
        else $error("absolute jump not three cycles");
    a_ind_wrap: assert property (kind == K_JIND && cyc == T4 |->
        o_addr[15:8] == $past(o_addr[15:8]) &&
        o_addr[7:0] == $past(o_addr[7:0]) + 8'h01)
        else $error("indirect pointer carried");
    a_branch_carry: assert property (kind == K_BRANCH && cyc == T3 |=>
        o_sync && o_addr == $past(o_addr))
        else $error("branch carry cycle wrong");
    a_stack_page: assert property (!o_rw |-> o_addr[15:8] == STACK_PAGE)
        else $error("write outside stack page");

    c_call: cover property (kind == K_CALL && cyc == T5);
    c_irq_entry: cover property (kind == K_BREAK && src == SRC_IRQ && cyc == T6);
    c_branch_cross: cover property (kind == K_BRANCH && cyc == T3);
    c_rets: cover property (kind == K_RETS && cyc == T5);
endmodule
`default_nettype wire

// >>> core/cfs_stack_if.sv
// stack pointer handshake between sequencer and stack pointer unit
`timescale 1ns/10ps
`default_nettype none
interface cfs_stack_if;
    logic       push;
    logic       pull;
    logic [7:0] sp;
    logic [7:0] sp_up;
    logic [7:0] sp_dn;
    modport ctrl (output push, output pull, input sp, input sp_up, input sp_dn);
    modport unit (input push, input pull, output sp, output sp_up, output sp_dn);
endinterface
`default_nettype wire

// >>> core/cfs_stack_ptr.sv
// stack pointer register with post-decrement push and pre-increment pull
`timescale 1ns/10ps
`default_nettype none
module cfs_stack_ptr
    import cfs_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    cfs_stack_if.unit   stk
);
    logic [7:0] sp;
    logic [7:0] next_sp;

    assign stk.sp    = sp;
    assign stk.sp_up = sp + 8'h01;
    assign stk.sp_dn = sp - 8'h01;

    always_comb begin
        next_sp = sp;
        if (stk.push) begin
            next_sp = stk.sp_dn;
        end else if (stk.pull) begin
            next_sp = stk.sp_up;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp <= RESET_SP;
        end else begin
            sp <= next_sp;
        end
    end
endmodule
`default_nettype wire

// >>> tb/cfs_mem_model.sv
// memory model on the processor bus
`timescale 1ns/10ps
`default_nettype none
module cfs_mem_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_rw,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [65536];
    // unprogrammed bytes read as a one-byte opcode
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'hea;
    // zero wait states; a written bus shows no stale read value
    assign o_rdata = i_rw ? mem[i_addr] : ~mem[i_addr];
    always @(posedge i_clk) begin
        if (!i_rw) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the control-flow bus sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
    import cfs_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        irq = 1'b0;
    logic        nmi = 1'b0;
    logic [7:0]  rdata;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rw;
    logic        sync;
    logic [7:0]  status;
    logic [27:0] bus;
    logic [27:0] prev;
    logic [27:0] prev2;
    int          miscompares = 0;
    int          tests_run = 0;
    // program image: address, byte
    logic [23:0] img [29] = '{24'hfffc_00, 24'hfffd_02, 24'hfffe_00, 24'hffff_06,
        24'hfffa_00, 24'hfffb_07, 24'h0200_20, 24'h0201_10, 24'h0202_03, 24'h0310_60,
        24'h0203_4c, 24'h0204_00, 24'h0205_04, 24'h0400_6c, 24'h0401_ff, 24'h0402_04,
        24'h04ff_80, 24'h6c80_30, 24'h6c81_05, 24'h6c82_10, 24'h6c83_7c, 24'h6d00_50,
        24'h6d01_02, 24'h6d04_00, 24'h0600_40, 24'h6d06_50, 24'h6d07_fe, 24'h0700_40,
        24'h0701_fe};
    // expected cycles: {sync,rw}, address, write data
    logic [27:0] rows [65] = '{28'h3_0200_00, 28'h1_0201_00, 28'h1_01fc_00, 28'h0_01fc_02,
        28'h0_01fb_02, 28'h1_0202_00, 28'h3_0310_00, 28'h1_0311_00, 28'h1_01fa_00,
        28'h1_01fb_00, 28'h1_01fc_00, 28'h1_0202_00, 28'h3_0203_00, 28'h1_0204_00,
        28'h1_0205_00, 28'h3_0400_00, 28'h1_0401_00, 28'h1_0402_00, 28'h1_04ff_00,
        28'h1_0400_00, 28'h3_6c80_00, 28'h1_6c81_00, 28'h3_6c82_00, 28'h1_6c83_00,
        28'h1_6c00_00, 28'h1_6d00_00, 28'h3_6d00_00, 28'h1_6d01_00, 28'h1_6d04_00,
        28'h3_6d04_00, 28'h1_6d05_00, 28'h0_01fc_6d, 28'h0_01fb_06, 28'h0_01fa_34,
        28'h1_fffe_00, 28'h1_ffff_00, 28'h3_0600_00, 28'h1_0601_00, 28'h1_01f9_00,
        28'h1_01fa_00, 28'h1_01fb_00, 28'h1_01fc_00, 28'h3_6d06_00, 28'h1_6d07_00,
        28'h1_6d06_00, 28'h3_6d06_00, 28'h0_01fc_6d, 28'h0_01fb_06, 28'h0_01fa_24,
        28'h1_fffa_00, 28'h1_fffb_00, 28'h3_0700_00, 28'h1_0701_00, 28'h1_01f9_00,
        28'h1_01fa_00, 28'h1_01fb_00, 28'h1_01fc_00, 28'h3_6d06_00, 28'h1_6d06_00,
        28'h0_01fc_6d, 28'h0_01fb_06, 28'h0_01fa_20, 28'h1_fffe_00, 28'h1_ffff_00,
        28'h3_0600_00};
    always #50 i_ref_clk = ~i_ref_clk;
    // write data masked on read cycles so only written bytes are compared
    assign bus = {2'b00, sync, rw, addr, rw ? 8'h00 : wdata};
    cfs_sequencer i_cfs_sequencer (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_rdata(rdata), .i_irq_req(irq), .i_nmi_req(nmi), .o_addr(addr),
        .o_wdata(wdata), .o_rw(rw), .o_sync(sync), .o_status(status));
    cfs_mem_model i_cfs_mem_model (.i_clk(i_ref_clk), .i_addr(addr), .i_wdata(wdata),
        .i_rw(rw), .o_rdata(rdata));
    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic step();
        prev2 = prev;
        prev = bus;
        @(negedge i_ref_clk);
    endtask
    task automatic wait_addr(input logic [15:0] a);
        for (int n = 0; n < 200 && addr !== a; n++) step();
        if (addr !== a) begin
            miscompares++;
            $display("CHECK FAILED wait exp %h got %h", a, addr);
            close_out();
        end
    endtask
    task automatic chk_rows(input int lo, input int hi);
        for (int k = lo; k < hi; k++) begin
            `CHK("bus", rows[k], bus)
            step();
        end
        $display("test rows %0d to %0d done", lo, hi - 1);
    endtask
    initial begin
        #1;
        foreach (img[k]) i_cfs_mem_model.mem[img[k][23:8]] = img[k][7:0];
        repeat (5) @(negedge i_ref_clk);
        `CHK("reset", {16'h0000, 2'b11, 8'h00, RESET_P}, {addr, rw, sync, wdata, status})
        i_reset_n = 1'b1;
        wait_addr(VEC_RST);
        step();
        `CHK("reset vector high", 16'hfffd, addr)
        step();
        chk_rows(0, 6);
        chk_rows(6, 12);
        chk_rows(12, 15);
        chk_rows(15, 20);
        chk_rows(20, 22);
        chk_rows(22, 26);
        chk_rows(26, 29);
        chk_rows(29, 36);
        chk_rows(36, 42);
        chk_rows(42, 46);
        // disable flag is set, so the maskable request must be ignored
        irq = 1'b1;
        repeat (30) begin
            `CHK("irq masked", 1'b1, addr !== VEC_IRQ)
            step();
        end
        $display("test irq masked done");
        nmi = 1'b1;
        wait_addr(16'h01fc);
        `CHK("nmi entry", {28'h3_6d06_00, 28'h1_6d06_00}, {prev2, prev})
        chk_rows(46, 52);
        `CHK("disable flag", 1'b1, status[P_I])
        // stand-in for a handler: stacked status with the disable flag clear
        i_cfs_mem_model.mem[16'h01fa] = 8'h20;
        // the return unmasks, so the held maskable request is taken at 6d06
        chk_rows(52, 65);
        `CHK("irq entry flag", 1'b1, status[P_I])
        nmi = 1'b0;
        irq = 1'b0;
        // second reset in mid-run must restart the entry sequence
        i_reset_n = 1'b0;
        @(negedge i_ref_clk);
        `CHK("mid-run reset", {16'h0000, 2'b11, 8'h00, RESET_P}, {addr, rw, sync, wdata, status})
        i_reset_n = 1'b1;
        wait_addr(VEC_RST);
        step();
        `CHK("restart vector high", 16'hfffd, addr)
        step();
        `CHK("restart fetch", 28'h3_0200_00, bus)
        $display("test mid-run reset done");
        close_out();
    end
endmodule
`default_nettype wire
